// ### hw/msp_map.svh
`ifndef MSP_MAP_SVH
`define MSP_MAP_SVH

// ----------------------------------------------------------------
// PWM timing
// ----------------------------------------------------------------
`define MSP_PWM_PERIOD 256
`define MSP_PWM_W 8
`define MSP_PWM_LAST 8'hff
`define MSP_PWM_FIRST 8'h00
`define MSP_SYNC_CYC 8'h04

// ----------------------------------------------------------------
// Step pointer and sequence table geometry
// ----------------------------------------------------------------
`define MSP_PTR_W 7
`define MSP_PTR_HOME 7'h00
`define MSP_FULL_STEP 7'h20
`define MSP_PHASE_OFS 7'h10
`define MSP_QUARTER 7'h20
`define MSP_QTR_TOP 6'h20

// ----------------------------------------------------------------
// Reference magnitude and programmable delay widths
// ----------------------------------------------------------------
`define MSP_MAG_W 8
`define MSP_CNT_W 16
`define MSP_HOLD_W 24

`endif

// ### hw/msp_pkg.sv
package msp_pkg;

  // Three-level select pin as seen after the input pad
  typedef enum logic [1:0] {
    MSP_TRI_LOW   = 2'h0,
    MSP_TRI_FLOAT = 2'h1,
    MSP_TRI_HIGH  = 2'h3
  } msp_tri_e;

  typedef enum logic [1:0] {
    MSP_DCY_FAST = 2'h0,
    MSP_DCY_SLOW = 2'h1,
    MSP_DCY_SMIX = 2'h3,
    MSP_DCY_DMIX = 2'h2
  } msp_decay_e;

  // One H-bridge: two legs and its active-low block control
  typedef struct packed {
    logic leg_p;
    logic leg_n;
    logic block_n;
  } msp_bridge_s;

endpackage

// ### hw/msp_sine_rom.sv
`timescale 1ns/1ps
`include "msp_map.svh"

module msp_sine_rom (
  input wire logic [`MSP_PTR_W-1:0] angle_i,  // Angle, 128 per turn
  output logic [`MSP_MAG_W-1:0] cos_mag_o,    // |cos| magnitude
  output logic [`MSP_MAG_W-1:0] sin_mag_o     // |sin| magnitude
);

  // ----------------------------------------------------------------
  // Quarter-wave table, full scale 8'hff
  // ----------------------------------------------------------------
  function automatic logic [7:0] qsin(input logic [5:0] k);
    logic [7:0] f;
    f = 8'hff;
    case (k)
      6'd0: f = 8'h00;
      6'd1: f = 8'h0d;
      6'd2: f = 8'h19;
      6'd3: f = 8'h25;
      6'd4: f = 8'h32;
      6'd5: f = 8'h3e;
      6'd6: f = 8'h4a;
      6'd7: f = 8'h56;
      6'd8: f = 8'h62;
      6'd9: f = 8'h6d;
      6'd10: f = 8'h78;
      6'd11: f = 8'h83;
      6'd12: f = 8'h8e;
      6'd13: f = 8'h98;
      6'd14: f = 8'ha2;
      6'd15: f = 8'hab;
      6'd16: f = 8'hb4;
      6'd17: f = 8'hbd;
      6'd18: f = 8'hc5;
      6'd19: f = 8'hcd;
      6'd20: f = 8'hd4;
      6'd21: f = 8'hdb;
      6'd22: f = 8'he1;
      6'd23: f = 8'he7;
      6'd24: f = 8'hec;
      6'd25: f = 8'hf0;
      6'd26: f = 8'hf4;
      6'd27: f = 8'hf7;
      6'd28: f = 8'hfa;
      6'd29: f = 8'hfc;
      6'd30: f = 8'hfe;
      default: f = 8'hff;
    endcase
    return f;
  endfunction

  // Index 0 gives sine, index 1 is shifted a quarter to give cosine
  logic [`MSP_PTR_W-1:0] ang [2];
  logic [`MSP_MAG_W-1:0] mag [2];
  assign ang[0] = angle_i;
  assign ang[1] = angle_i + `MSP_QUARTER;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_q
      wire [5:0] k = {1'b0, ang[g][4:0]};
      // Odd quarters run the table backwards
      wire [5:0] idx = ang[g][5] ? `MSP_QTR_TOP - k : k;
      assign mag[g] = qsin(idx);
    end
  endgenerate

  assign sin_mag_o = mag[0];
  assign cos_mag_o = mag[1];

endmodule

// ### hw/msp_sequencer.sv
`timescale 1ns/1ps
`include "msp_map.svh"

module msp_sequencer #(
  parameter int CNT_W = `MSP_CNT_W,
  parameter int HOLD_W = `MSP_HOLD_W
) (
  input wire logic clk_i,                        // System clock
  input wire logic resetn_i,                     // Sync reset, low
  input wire logic ce_i,                         // Clock enable
  input wire logic step_n_i,                     // Step, low pulse
  input wire logic direction_up_i,               // Step direction
  input wire logic oe_n_i,                       // Drive enable, low
  input wire logic resolution_sel_bin_i,         // Two-level select
  input wire msp_pkg::msp_tri_e resolution_sel_tri_i, // Tri select
  input wire logic decay_style_sel_i,            // Decay style select
  input wire logic dcy_down_level_i,             // Fast-delay pin level
  input wire logic [CNT_W-1:0] dcy_down_cnt_i,   // Falling fast time
  input wire logic [CNT_W-1:0] dcy_up_cnt_i,     // Rising fast time
  input wire logic [`MSP_PWM_W-1:0] blank_cnt_i, // Blanking time
  input wire logic [HOLD_W-1:0] hold_delay_set_i,// Hold delay, 0 off
  input wire logic winding_a_current_cmp_i,      // A sense trip
  input wire logic winding_b_current_cmp_i,      // B sense trip
  output logic bridge_a_leg_p_o,                 // Bridge A leg P
  output logic bridge_a_leg_n_o,                 // Bridge A leg N
  output logic bridge_b_leg_p_o,                 // Bridge B leg P
  output logic bridge_b_leg_n_o,                 // Bridge B leg N
  output logic bridge_a_block_n_o,               // Bridge A block
  output logic bridge_b_block_n_o,               // Bridge B block
  output logic [`MSP_MAG_W-1:0] ref_a_o,         // A reference code
  output logic [`MSP_MAG_W-1:0] ref_b_o,         // B reference code
  output logic hold_ref_sel_o,                   // Holding ref in use
  output logic home_n_o,                         // Home pin value
  output logic home_oe_o,                        // Home pin enable
  output logic sync_n_o,                         // Sync pin value
  output logic sync_oe_o                         // Sync pin enable
);

  // ----------------------------------------------------------------
  // Step input synchroniser and edge detect
  // ----------------------------------------------------------------
  logic step_s1_q, step_s2_q, step_s3_q;
  wire step_fall = step_s3_q & ~step_s2_q;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      step_s1_q <= 1'b1;
      step_s2_q <= 1'b1;
      step_s3_q <= 1'b1;
    end else if (ce_i) begin
      step_s1_q <= step_n_i;
      step_s2_q <= step_s1_q;
      step_s3_q <= step_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Resolution, pointer and sequence table
  // ----------------------------------------------------------------
  wire [2:0] tri_base =
    (resolution_sel_tri_i == msp_pkg::MSP_TRI_LOW)   ? 3'h0 :
    (resolution_sel_tri_i == msp_pkg::MSP_TRI_FLOAT) ? 3'h2 : 3'h4;
  wire [2:0] res_shift = tri_base + {2'h0, resolution_sel_bin_i};
  wire [`MSP_PTR_W-1:0] step_size = `MSP_FULL_STEP >> res_shift;

  logic [`MSP_PTR_W-1:0] ptr_q;
  wire [`MSP_PTR_W-1:0] ptr_up = ptr_q + step_size;
  wire [`MSP_PTR_W-1:0] ptr_dn = ptr_q - step_size;
  wire [`MSP_PTR_W-1:0] ptr_d = direction_up_i ? ptr_up : ptr_dn;
  wire [`MSP_PTR_W-1:0] angle = ptr_q + `MSP_PHASE_OFS;

  logic [`MSP_MAG_W-1:0] cos_mag, sin_mag;
  msp_sine_rom i_msp_sine_rom (
    .angle_i(angle),
    .cos_mag_o(cos_mag),
    .sin_mag_o(sin_mag)
  );

  // Winding A follows cosine, B follows sine; sign picks bridge polarity
  wire [`MSP_MAG_W-1:0] mag_new [2];
  assign mag_new[0] = cos_mag;
  assign mag_new[1] = sin_mag;
  wire [1:0] pos;
  assign pos[0] = ~(angle[6] ^ angle[5]);
  assign pos[1] = ~angle[6];

  // A step moves the pointer; the cycle after, the table shows the
  // new magnitudes while ref_q still holds the old ones.
  logic moved_q;
  logic [`MSP_MAG_W-1:0] ref_q [2];

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ptr_q <= `MSP_PTR_HOME;
      moved_q <= 1'b0;
    end else if (ce_i) begin
      if (step_fall) begin
        ptr_q <= ptr_d;
      end
      moved_q <= step_fall;
    end
  end

  // ----------------------------------------------------------------
  // Decay mode decode
  // ----------------------------------------------------------------
  wire msp_pkg::msp_decay_e mode =
    decay_style_sel_i ?
      (dcy_down_level_i ? msp_pkg::MSP_DCY_SLOW : msp_pkg::MSP_DCY_FAST) :
      ((dcy_up_cnt_i == '0) ? msp_pkg::MSP_DCY_SMIX
                            : msp_pkg::MSP_DCY_DMIX);
  wire mixed = (mode == msp_pkg::MSP_DCY_SMIX) ||
               (mode == msp_pkg::MSP_DCY_DMIX);

  // ----------------------------------------------------------------
  // PWM period, sync and blanking
  // ----------------------------------------------------------------
  logic [`MSP_PWM_W-1:0] pwm_cnt_q;
  wire cyc_end = (pwm_cnt_q == `MSP_PWM_LAST);
  wire blank_w = (pwm_cnt_q < blank_cnt_i);
  wire sync_act = (pwm_cnt_q < `MSP_SYNC_CYC);
  logic sync_oe_q, sync_n_q;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pwm_cnt_q <= `MSP_PWM_FIRST;
      sync_oe_q <= 1'b0;
      sync_n_q <= 1'b1;
    end else if (ce_i) begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      sync_oe_q <= sync_act;
      sync_n_q <= ~sync_act;
    end
  end

  // ----------------------------------------------------------------
  // Holding torque timer
  // ----------------------------------------------------------------
  logic [HOLD_W-1:0] hold_cnt_q;
  logic hold_q;
  wire hold_en = (hold_delay_set_i != '0);
  wire hold_due = hold_en && (hold_cnt_q >= hold_delay_set_i);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      hold_cnt_q <= '0;
      hold_q <= 1'b0;
    end else if (ce_i) begin
      if (step_fall) begin
        hold_cnt_q <= '0;
        hold_q <= 1'b0;
      end else begin
        if (!hold_due) begin
          hold_cnt_q <= hold_cnt_q + 1'b1;
        end
        hold_q <= hold_due;
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-winding chopper, decay timer and bridge drive
  // ----------------------------------------------------------------
  logic [1:0] on_q;
  logic [1:0] fast_w;
  msp_pkg::msp_bridge_s br_q [2];
  wire [1:0] cmp = {winding_b_current_cmp_i, winding_a_current_cmp_i};

  genvar w;
  generate
    for (w = 0; w < 2; w++) begin : g_wnd
      logic [CNT_W-1:0] tmr_q;
      wire falling = mag_new[w] < ref_q[w];
      // Rising winding: single-mixed gives none, dual-mixed its own time
      wire [CNT_W-1:0] load =
        (mode == msp_pkg::MSP_DCY_SMIX) ?
          (falling ? dcy_down_cnt_i : '0) :
        (mode == msp_pkg::MSP_DCY_DMIX) ?
          (falling ? dcy_down_cnt_i : dcy_up_cnt_i) :
        '0;
      wire trip = on_q[w] && !blank_w && cmp[w];
      // In the mixed modes, idle means the timer ran out, which leaves slow decay
      assign fast_w[w] = (mode == msp_pkg::MSP_DCY_FAST) ||
                         (mixed && (tmr_q != '0));
      wire chop = fast_w[w] ? 1'b0 : ~on_q[w];
      msp_pkg::msp_bridge_s drv;
      assign drv.leg_p = ~oe_n_i & ~chop & pos[w];
      assign drv.leg_n = ~oe_n_i & ~chop & ~pos[w];
      assign drv.block_n = ~oe_n_i & (fast_w[w] ? on_q[w] : 1'b1);

      always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
          on_q[w] <= 1'b0;
          tmr_q <= '0;
          ref_q[w] <= '0;
          br_q[w] <= '0;
        end else if (ce_i) begin
          if (cyc_end) begin
            on_q[w] <= 1'b1;
          end else if (trip) begin
            on_q[w] <= 1'b0;
          end
          if (moved_q) begin
            tmr_q <= load;
          end else if (tmr_q != '0) begin
            tmr_q <= tmr_q - 1'b1;
          end
          ref_q[w] <= mag_new[w];
          br_q[w] <= drv;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Home indicator
  // ----------------------------------------------------------------
  logic home_oe_q, home_n_q;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      home_oe_q <= 1'b1;
      home_n_q <= 1'b0;
    end else if (ce_i) begin
      home_oe_q <= (ptr_q == `MSP_PTR_HOME);
      home_n_q <= (ptr_q != `MSP_PTR_HOME);
    end
  end

  // ----------------------------------------------------------------
  // Output ports
  // ----------------------------------------------------------------
  assign bridge_a_leg_p_o = br_q[0].leg_p;
  assign bridge_a_leg_n_o = br_q[0].leg_n;
  assign bridge_a_block_n_o = br_q[0].block_n;
  assign bridge_b_leg_p_o = br_q[1].leg_p;
  assign bridge_b_leg_n_o = br_q[1].leg_n;
  assign bridge_b_block_n_o = br_q[1].block_n;
  assign ref_a_o = ref_q[0];
  assign ref_b_o = ref_q[1];
  assign hold_ref_sel_o = hold_q;
  assign home_n_o = home_n_q;
  assign home_oe_o = home_oe_q;
  assign sync_n_o = sync_n_q;
  assign sync_oe_o = sync_oe_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_fall;
    ce_i && step_fall;
  endsequence

  property p_period;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && cyc_end |=> pwm_cnt_q == `MSP_PWM_FIRST;
  endproperty
  a_period: assert property (p_period)
    else $error("PWM counter did not wrap after 256 clocks");

  property p_start;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && cyc_end |=> on_q == 2'h3;
  endproperty
  a_start: assert property (p_start)
    else $error("Windings did not start together");

  property p_cut;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && !cyc_end && on_q[0] && !blank_w && winding_a_current_cmp_i
      |=> !on_q[0] ##1 (!on_q[0] || $past(cyc_end));
  endproperty
  a_cut: assert property (p_cut)
    else $error("Winding A not cut off by its comparator");

  property p_blank;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && blank_w && !cyc_end && on_q[1] |=> on_q[1];
  endproperty
  a_blank: assert property (p_blank)
    else $error("Comparator acted inside blanking time");

  property p_home;
    @(posedge clk_i)
    !resetn_i |=> ptr_q == `MSP_PTR_HOME;
  endproperty
  a_home: assert property (p_home)
    else $error("Pointer not at home after reset");

  property p_step;
    @(posedge clk_i) disable iff (!resetn_i)
    s_fall ##0 direction_up_i |=>
      ptr_q == $past(ptr_q) + $past(step_size);
  endproperty
  a_step: assert property (p_step)
    else $error("Forward step moved the pointer wrongly");

  property p_step_dn;
    @(posedge clk_i) disable iff (!resetn_i)
    s_fall ##0 !direction_up_i |=>
      ptr_q == $past(ptr_q) - $past(step_size);
  endproperty
  a_step_dn: assert property (p_step_dn)
    else $error("Reverse step moved the pointer wrongly");

  property p_off;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && oe_n_i |=> !bridge_a_leg_p_o && !bridge_a_leg_n_o &&
      !bridge_b_leg_p_o && !bridge_b_leg_n_o &&
      !bridge_a_block_n_o && !bridge_b_block_n_o;
  endproperty
  a_off: assert property (p_off)
    else $error("Bridge outputs not forced low while disabled");

  property p_home_ind;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i |=> home_oe_o == ($past(ptr_q) == `MSP_PTR_HOME);
  endproperty
  a_home_ind: assert property (p_home_ind)
    else $error("Home indicator disagrees with pointer");

  property p_sync;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && cyc_end ##1 ce_i |=> sync_oe_o && !sync_n_o;
  endproperty
  a_sync: assert property (p_sync)
    else $error("No sync pulse at cycle start");

  property p_no_hold;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && !hold_en |=> !hold_ref_sel_o;
  endproperty
  a_no_hold: assert property (p_no_hold)
    else $error("Holding reference used while disabled");

  property p_slow;
    @(posedge clk_i) disable iff (!resetn_i)
    ce_i && !oe_n_i && mode == msp_pkg::MSP_DCY_SLOW
      |=> bridge_a_block_n_o && bridge_b_block_n_o;
  endproperty
  a_slow: assert property (p_slow)
    else $error("Block outputs chopped in slow decay");

endmodule

// ### verif/msp_winding_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// One motor winding with its sense resistor and comparator
// ----------------------------------------------------------------
module msp_winding_model (
  input wire logic clk_i,               // System clock
  input wire msp_pkg::msp_bridge_s br_i, // Bridge drive from the block
  input wire logic [7:0] ref_i,         // Reference code of the winding
  output logic cmp_o                    // High when sense reaches ref
);
  logic [9:0] cur_q = 10'h000;
  logic drive;

  assign drive = br_i.block_n & (br_i.leg_p ^ br_i.leg_n);
  // Ramp outruns decay so a full reference still trips inside a cycle
  always @(posedge clk_i) begin
    if (drive)
      cur_q <= (cur_q > 10'h3f0) ? cur_q : cur_q + 10'h004;
    else
      cur_q <= (cur_q < 10'h002) ? 10'h000 : cur_q - 10'h002;
  end
  assign cmp_o = cur_q >= {2'h0, ref_i};
endmodule

// ### verif/microstep_pwm_chopper_sequencer_tb_top.sv
`timescale 1ns/1ps

module microstep_pwm_chopper_sequencer_tb_top;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce = 1'b1;
  logic step_n_i = 1'b1;
  logic dir_up = 1'b1;
  logic oe_n_i = 1'b0;
  logic bin = 1'b1;
  msp_pkg::msp_tri_e tri_sel = msp_pkg::MSP_TRI_HIGH;
  logic dsel = 1'b1;
  logic dlev = 1'b0;
  logic [15:0] dn_cnt = 16'h0000;
  logic [15:0] up_cnt = 16'h0000;
  logic [7:0] blank = 8'h10;
  logic [23:0] hold = 24'h000000;
  logic cmp_a;
  logic cmp_b;
  logic a_p, a_n, b_p, b_n, a_blk, b_blk;
  logic [7:0] ref_a;
  logic [7:0] ref_b;
  logic hold_sel, home_n, home_oe, sync_n, sync_oe;
  logic a_b0, b_b0, a_l0, b_l0, a_lc;
  int skew, a_on, hi;
  int mismatches = 0;
  int check_count = 0;

  always #2.5 clk_i = ~clk_i;

  msp_sequencer i_msp_sequencer (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
    .step_n_i(step_n_i), .direction_up_i(dir_up), .oe_n_i(oe_n_i),
    .resolution_sel_bin_i(bin), .resolution_sel_tri_i(tri_sel),
    .decay_style_sel_i(dsel), .dcy_down_level_i(dlev),
    .dcy_down_cnt_i(dn_cnt), .dcy_up_cnt_i(up_cnt),
    .blank_cnt_i(blank), .hold_delay_set_i(hold),
    .winding_a_current_cmp_i(cmp_a), .winding_b_current_cmp_i(cmp_b),
    .bridge_a_leg_p_o(a_p), .bridge_a_leg_n_o(a_n),
    .bridge_b_leg_p_o(b_p), .bridge_b_leg_n_o(b_n),
    .bridge_a_block_n_o(a_blk), .bridge_b_block_n_o(b_blk),
    .ref_a_o(ref_a), .ref_b_o(ref_b), .hold_ref_sel_o(hold_sel),
    .home_n_o(home_n), .home_oe_o(home_oe),
    .sync_n_o(sync_n), .sync_oe_o(sync_oe));

  msp_winding_model i_msp_winding_model_a (
    .clk_i(clk_i), .br_i({a_p, a_n, a_blk}), .ref_i(ref_a),
    .cmp_o(cmp_a));
  msp_winding_model i_msp_winding_model_b (
    .clk_i(clk_i), .br_i({b_p, b_n, b_blk}), .ref_i(ref_b),
    .cmp_o(cmp_b));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic rst();
    resetn_i = 1'b0;
    cyc(6);
    chk({a_p, a_n, b_p, b_n, a_blk, b_blk}, 6'h00);
    chk({home_oe, home_n}, 2'h2);
    resetn_i = 1'b1;
    cyc(3);
  endtask

  // Low for three cycles, high for three: meets the spacing rule
  task automatic do_step(input logic up);
    dir_up = up;
    step_n_i = 1'b0;
    cyc(3);
    step_n_i = 1'b1;
    cyc(3);
  endtask

  task automatic watch(input int n);
    logic pa;
    logic pb;
    logic [1:0] la;
    la = {a_p, a_n};
    pa = a_blk;
    pb = b_blk;
    {a_b0, b_b0, a_l0, b_l0, a_lc} = 5'h00;
    skew = 0;
    a_on = 0;
    hi = 0;
    repeat (n) begin
      cyc(1);
      if (a_blk === 1'b0) a_b0 = 1'b1;
      if (b_blk === 1'b0) b_b0 = 1'b1;
      if ({a_p, a_n} === 2'h0) a_l0 = 1'b1;
      if ({b_p, b_n} === 2'h0) b_l0 = 1'b1;
      if ({a_p, a_n} !== la) a_lc = 1'b1;
      if ((a_blk & ~pa) !== (b_blk & ~pb)) skew++;
      if (a_blk === 1'b1) a_on++;
      if ((|{a_p, a_n, b_p, b_n, a_blk, b_blk}) !== 1'b0) hi++;
      la = {a_p, a_n};
      pa = a_blk;
      pb = b_blk;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_sync();
    int n;
    int w;
    int bad;
    n = 0;
    w = 0;
    bad = 0;
    // Skip a pulse already running after reset: it is only partly seen
    while (sync_oe === 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (sync_oe !== 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    while (sync_oe === 1'b1 && w < 600) begin
      if (sync_n !== 1'b0) bad++;
      cyc(1);
      w++;
    end
    n = w;
    while (sync_oe !== 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    chk(w, 4);
    chk(bad, 0);
    chk(n, 256);
    // A frozen clock enable stretches the period by the frozen cycles
    ce = 1'b0;
    cyc(20);
    ce = 1'b1;
    n = 20;
    while (sync_oe === 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    while (sync_oe !== 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    chk(n, 276);
  endtask

  task automatic t_res();
    int units;
    for (int i = 0; i < 6; i++) begin
      bin = i[0];
      tri_sel = (i < 2) ? msp_pkg::MSP_TRI_LOW :
                (i < 4) ? msp_pkg::MSP_TRI_FLOAT : msp_pkg::MSP_TRI_HIGH;
      rst();
      units = 32 >> i;
      do_step(1'b1);
      chk(home_oe, 1'b0);
      repeat (128 / units - 1) do_step(1'b1);
      chk({home_oe, home_n}, 2'h2);
    end
  endtask

  // Half steps land on the quarter points of the magnitude table
  task automatic t_dir();
    bin = 1'b1;
    tri_sel = msp_pkg::MSP_TRI_LOW;
    rst();
    chk({ref_a, ref_b}, 16'hb4b4);
    do_step(1'b1);
    chk({ref_a, ref_b}, 16'h00ff);
    do_step(1'b0);
    chk({home_oe, home_n}, 2'h2);
    do_step(1'b0);
    chk({ref_a, ref_b}, 16'hff00);
  endtask

  task automatic t_decay();
    rst();
    dsel = 1'b1;
    dlev = 1'b1;
    cyc(256);
    watch(512);
    chk({a_b0, b_b0, a_l0, b_l0}, 4'h3);
    dlev = 1'b0;
    cyc(256);
    watch(512);
    chk({a_b0, b_b0, a_l0, b_l0, a_lc}, 5'h18);
    chk(skew, 0);
    oe_n_i = 1'b1;
    cyc(2);
    watch(300);
    chk(hi, 0);
    oe_n_i = 1'b0;
  endtask

  // Zero reference trips at the first sampled cycle after blanking
  task automatic t_blank();
    rst();
    do_step(1'b1);
    blank = 8'h14;
    cyc(256);
    watch(512);
    chk(a_on, 42);
    blank = 8'h28;
    cyc(256);
    watch(512);
    chk(a_on, 82);
    blank = 8'h10;
  endtask

  task automatic t_mixed();
    dsel = 1'b0;
    dn_cnt = 16'h0258;
    up_cnt = 16'h0000;
    rst();
    cyc(300);
    watch(512);
    chk({a_b0, b_b0}, 2'h0);
    do_step(1'b1);
    watch(500);
    chk({a_b0, b_b0}, 2'h2);
    cyc(300);
    watch(512);
    chk({a_b0, b_b0}, 2'h0);
    dn_cnt = 16'h0320;
    up_cnt = 16'h00c8;
    rst();
    do_step(1'b1);
    watch(150);
    chk({a_b0, b_b0}, 2'h3);
    cyc(100);
    watch(256);
    chk({a_b0, b_b0}, 2'h2);
  endtask

  task automatic t_hold();
    hold = 24'h000032;
    rst();
    do_step(1'b1);
    cyc(40);
    chk(hold_sel, 1'b0);
    cyc(15);
    chk(hold_sel, 1'b1);
    do_step(1'b1);
    chk(hold_sel, 1'b0);
    hold = 24'h000000;
    rst();
    do_step(1'b1);
    cyc(200);
    chk(hold_sel, 1'b0);
  endtask

  initial begin
    #400000;
    mismatches++;
    summarize();
  end

  initial begin
    rst();
    t_sync();
    t_res();
    t_dir();
    t_decay();
    t_blank();
    t_mixed();
    t_hold();
    summarize();
  end
endmodule
